// file: core/cwp_pkg.sv
// What this block does
// - bit 13 set allows low-voltage entry; clear demands high voltage on master clear.
// - bit 11 set disables the low-power brown-out reset; clear enables it.
// - bit 10 set picks the low brown-out trip point; clear picks the high one.
// - unimplemented bits 12, 8 and 7..2 always read as one.
// - code protect low blocks external program and write; external program memory reads give zeros.
// - cpu fetch and internal reads of program memory are never gated here.
// - self-write permission follows the control enable bit and the write-protect field, not the code-protect bit.
// - field bits 1:0 pick the guarded region; self-writes inside it are rejected.
// - code protection is lifted only by a bulk erase of the whole device.
package cwp_pkg;
	localparam int CFG_W = 14;
	localparam int PM_AW = 11;
	localparam int REG_AW = 4;

	// configuration word two field positions
	localparam int BIT_LV_PROG = 13;
	localparam int BIT_LP_BOR_DIS = 11;
	localparam int BIT_BOR_TRIP = 10;
	localparam int BIT_STACK_RST = 9;
	localparam int BIT_SW_PROT_HI = 1;
	localparam int BIT_SW_PROT_LO = 0;
	localparam logic [CFG_W-1:0] CFG2_UNIMPL_MASK = 14'h11fc;
	localparam logic [CFG_W-1:0] CFG2_BLANK = 14'h3fff;
	localparam logic PROT_N_BLANK = 1'b1;
	localparam logic [1:0] SW_PROT_NONE = 2'h3;

	// register indices, byte address is four times the index
	localparam logic [REG_AW-1:0] REG_CFG2 = 4'h0;
	localparam logic [REG_AW-1:0] REG_STATUS = 4'h1;
	localparam logic [REG_AW-1:0] REG_CTRL = 4'h2;

	// status bits and the control enable bit
	localparam int ST_PROG_MODE = 0;
	localparam int ST_PROT_ON = 1;
	localparam int ST_SW_REFUSED = 2;
	localparam int ST_EXT_REFUSED = 3;
	localparam int ST_LOADED = 4;
	localparam int CTRL_SW_EN = 0;

	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		CMD_READ = 2'b00,
		CMD_WRITE = 2'b01,
		CMD_SET_PROT = 2'b10,
		CMD_BULK_ERASE = 2'b11
	} cwp_cmd_t;

	typedef struct packed {
		logic valid;
		cwp_cmd_t cmd;
		logic cfg_space;
		logic [PM_AW-1:0] addr;
		logic [CFG_W-1:0] data;
	} cwp_prg_req_t;

	typedef struct packed {
		logic valid;
		logic refused;
		logic [CFG_W-1:0] data;
	} cwp_prg_rsp_t;

	typedef struct packed {
		logic we;
		logic re;
		logic erase;
		logic [PM_AW-1:0] addr;
		logic [CFG_W-1:0] data;
	} cwp_pm_req_t;

	typedef struct packed {
		logic valid;
		logic [PM_AW-1:0] addr;
		logic [CFG_W-1:0] data;
	} cwp_self_wr_t;
endpackage

// file: core/cwp_config_word_protect.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module cwp_config_word_protect #(
	parameter logic [cwp_pkg::PM_AW-1:0] REGION_TOP_0 = 11'h7ff,
	parameter logic [cwp_pkg::PM_AW-1:0] REGION_TOP_1 = 11'h3ff,
	parameter logic [cwp_pkg::PM_AW-1:0] REGION_TOP_2 = 11'h1ff
) (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic [cwp_pkg::CFG_W-1:0] i_nv_cfg2,
	input wire logic i_nv_code_protect_n,
	input wire logic i_master_clear_pin_hv,
	input wire logic i_lv_entry_key,
	input wire cwp_pkg::cwp_prg_req_t i_prg_req,
	output cwp_pkg::cwp_prg_rsp_t o_prg_rsp,
	input wire cwp_pkg::cwp_self_wr_t i_self_wr,
	output logic o_self_wr_refused,
	output cwp_pkg::cwp_pm_req_t o_pm_req,
	input wire logic [cwp_pkg::CFG_W-1:0] i_pm_rdata,
	output logic [cwp_pkg::CFG_W-1:0] o_nv_cfg2,
	output logic o_nv_code_protect_n,
	output logic o_prog_mode,
	output logic o_lp_brownout_en,
	output logic o_bor_low_trip,
	output logic o_stack_fault_reset_enable,
	input wire logic [cwp_pkg::REG_AW-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_we,
	input wire logic i_reg_re,
	output logic [31:0] o_reg_rdata
);
	import cwp_pkg::*;

	// guarded region always starts at address zero and ends at the table entry
	function automatic logic in_region(input logic [PM_AW-1:0] addr, input logic [1:0] sel);
		logic hit;
		hit = 1'b0;
		case (sel)
			2'b00: hit = (addr <= REGION_TOP_0);
			2'b01: hit = (addr <= REGION_TOP_1);
			2'b10: hit = (addr <= REGION_TOP_2);
			SW_PROT_NONE: hit = 1'b0;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// pin synchronisers
	logic hv_s1_r, hv_s2_r, key_s1_r, key_s2_r;
	logic hv_s1_nxt, key_s1_nxt;
	always_comb begin
		hv_s1_nxt = i_master_clear_pin_hv;
		key_s1_nxt = i_lv_entry_key;
	end
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hv_s1_r <= 1'b0;
			hv_s2_r <= 1'b0;
			key_s1_r <= 1'b0;
			key_s2_r <= 1'b0;
		end else begin
			hv_s1_r <= hv_s1_nxt;
			hv_s2_r <= hv_s1_r;
			key_s1_r <= key_s1_nxt;
			key_s2_r <= key_s1_r;
		end
	end

	// configuration state, loaded from the non-volatile copy after reset release
	logic [CFG_W-1:0] cfg2_r, cfg2_nxt;
	logic prot_n_r, prot_n_nxt;
	logic loaded_r, loaded_nxt;
	logic prog_mode_r, prog_mode_nxt;
	logic prot_on, ext_ok, ext_refuse;
	logic [1:0] sw_prot_sel;

	assign prot_on = !prot_n_r;
	assign sw_prot_sel = cfg2_r[BIT_SW_PROT_HI:BIT_SW_PROT_LO];
	assign ext_ok = i_prg_req.valid && prog_mode_r && loaded_r;

	always_comb begin
		cfg2_nxt = cfg2_r;
		prot_n_nxt = prot_n_r;
		loaded_nxt = 1'b1;
		// entry needs high voltage unless low-voltage entry is enabled
		prog_mode_nxt = hv_s2_r || (cfg2_r[BIT_LV_PROG] && key_s2_r);
		if (!loaded_r) begin
			cfg2_nxt = i_nv_cfg2 | CFG2_UNIMPL_MASK;
			prot_n_nxt = i_nv_code_protect_n;
		end else if (ext_ok) begin
			case (i_prg_req.cmd)
				CMD_BULK_ERASE: begin
					cfg2_nxt = CFG2_BLANK;
					prot_n_nxt = PROT_N_BLANK;
				end
				CMD_SET_PROT: prot_n_nxt = 1'b0;
				CMD_WRITE: begin
					if (i_prg_req.cfg_space && !prot_on) begin
						cfg2_nxt = i_prg_req.data | CFG2_UNIMPL_MASK;
					end
				end
				default: cfg2_nxt = cfg2_r;
			endcase
		end
	end
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg2_r <= CFG2_BLANK;
			prot_n_r <= PROT_N_BLANK;
			loaded_r <= 1'b0;
			prog_mode_r <= 1'b0;
		end else begin
			cfg2_r <= cfg2_nxt;
			prot_n_r <= prot_n_nxt;
			loaded_r <= loaded_nxt;
			prog_mode_r <= prog_mode_nxt;
		end
	end

	// external write to program memory blocked while protected
	assign ext_refuse = ext_ok && (i_prg_req.cmd == CMD_WRITE) && prot_on;

	// self-write checked against the enable bit and the region; code protect plays no part
	logic sw_en_r, sw_en_nxt;
	logic sw_hit, sw_refuse, sw_pass;
	assign sw_hit = i_self_wr.valid && !prog_mode_r;
	assign sw_refuse = sw_hit && (!sw_en_r || in_region(i_self_wr.addr, sw_prot_sel));
	assign sw_pass = sw_hit && !sw_refuse;
	assign o_self_wr_refused = sw_refuse;

	// program memory port; cpu fetch and reads use their own path untouched
	always_comb begin
		o_pm_req = '0;
		if (ext_ok && !i_prg_req.cfg_space) begin
			o_pm_req.addr = i_prg_req.addr;
			o_pm_req.data = i_prg_req.data;
			o_pm_req.re = (i_prg_req.cmd == CMD_READ);
			o_pm_req.we = (i_prg_req.cmd == CMD_WRITE) && !prot_on;
		end else if (sw_pass) begin
			o_pm_req.addr = i_self_wr.addr;
			o_pm_req.data = i_self_wr.data;
			o_pm_req.we = 1'b1;
		end
		o_pm_req.erase = ext_ok && (i_prg_req.cmd == CMD_BULK_ERASE);
	end

	// programmer answer, one cycle after the request
	cwp_prg_rsp_t rsp_r, rsp_nxt;
	logic rd_pm_r, rd_pm_nxt, rd_zero_r, rd_zero_nxt;
	always_comb begin
		rsp_nxt = '0;
		rd_pm_nxt = 1'b0;
		rd_zero_nxt = 1'b0;
		if (ext_ok) begin
			rsp_nxt.valid = 1'b1;
			rsp_nxt.refused = ext_refuse || (i_prg_req.cfg_space
				&& (i_prg_req.cmd == CMD_WRITE) && prot_on);
			if (i_prg_req.cmd == CMD_READ) begin
				if (i_prg_req.cfg_space) begin
					rsp_nxt.data = cfg2_r | CFG2_UNIMPL_MASK;
				end else begin
					rd_pm_nxt = 1'b1;
					rd_zero_nxt = prot_on;
				end
			end
		end
	end
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rsp_r <= '0;
			rd_pm_r <= 1'b0;
			rd_zero_r <= 1'b0;
		end else begin
			rsp_r <= rsp_nxt;
			rd_pm_r <= rd_pm_nxt;
			rd_zero_r <= rd_zero_nxt;
		end
	end
	always_comb begin
		o_prg_rsp = rsp_r;
		if (rd_pm_r) begin
			o_prg_rsp.data = rd_zero_r ? '0 : i_pm_rdata;
		end
	end

	// register file: sticky refusals, set wins over write-one-to-clear
	logic sw_ref_r, sw_ref_nxt, ext_ref_r, ext_ref_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic st_wr, ctrl_wr;
	assign st_wr = i_reg_we && (i_reg_addr == REG_STATUS);
	assign ctrl_wr = i_reg_we && (i_reg_addr == REG_CTRL);
	always_comb begin
		sw_en_nxt = ctrl_wr ? i_reg_wdata[CTRL_SW_EN] : sw_en_r;
		sw_ref_nxt = sw_ref_r;
		ext_ref_nxt = ext_ref_r;
		if (st_wr && i_reg_wdata[ST_SW_REFUSED]) begin
			sw_ref_nxt = 1'b0;
		end
		if (st_wr && i_reg_wdata[ST_EXT_REFUSED]) begin
			ext_ref_nxt = 1'b0;
		end
		if (sw_refuse) begin
			sw_ref_nxt = 1'b1;
		end
		if (rsp_nxt.refused) begin
			ext_ref_nxt = 1'b1;
		end
		rdata_nxt = REG_RESET;
		if (i_reg_re) begin
			case (i_reg_addr)
				REG_CFG2: rdata_nxt = {18'h0_0000, cfg2_r | CFG2_UNIMPL_MASK};
				REG_STATUS: begin
					rdata_nxt[ST_PROG_MODE] = prog_mode_r;
					rdata_nxt[ST_PROT_ON] = prot_on;
					rdata_nxt[ST_SW_REFUSED] = sw_ref_r;
					rdata_nxt[ST_EXT_REFUSED] = ext_ref_r;
					rdata_nxt[ST_LOADED] = loaded_r;
				end
				REG_CTRL: rdata_nxt[CTRL_SW_EN] = sw_en_r;
				default: rdata_nxt = REG_RESET;
			endcase
		end
	end
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sw_en_r <= 1'b0;
			sw_ref_r <= 1'b0;
			ext_ref_r <= 1'b0;
			rdata_r <= REG_RESET;
		end else begin
			sw_en_r <= sw_en_nxt;
			sw_ref_r <= sw_ref_nxt;
			ext_ref_r <= ext_ref_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_reg_rdata = rdata_r;
	assign o_nv_cfg2 = cfg2_r;
	assign o_nv_code_protect_n = prot_n_r;
	assign o_prog_mode = prog_mode_r;
	assign o_lp_brownout_en = !cfg2_r[BIT_LP_BOR_DIS];
	assign o_bor_low_trip = cfg2_r[BIT_BOR_TRIP];
	assign o_stack_fault_reset_enable = cfg2_r[BIT_STACK_RST];
endmodule

// file: verification/cwp_checker.sv
`timescale 1ns/1ps
module cwp_checker #(
	parameter logic [cwp_pkg::PM_AW-1:0] REGION_TOP_2 = 11'h1ff
) (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_master_clear_pin_hv,
	input wire cwp_pkg::cwp_prg_req_t i_prg_req,
	input wire cwp_pkg::cwp_prg_rsp_t o_prg_rsp,
	input wire cwp_pkg::cwp_self_wr_t i_self_wr,
	input wire logic o_self_wr_refused,
	input wire cwp_pkg::cwp_pm_req_t o_pm_req,
	input wire logic [cwp_pkg::CFG_W-1:0] o_nv_cfg2,
	input wire logic o_nv_code_protect_n,
	input wire logic o_prog_mode,
	input wire logic o_lp_brownout_en
);
	import cwp_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	sequence erase_req;
		i_prg_req.valid && o_prog_mode && i_prg_req.cmd == CMD_BULK_ERASE;
	endsequence
	sequence erase_done;
		o_prg_rsp.valid && o_nv_code_protect_n && o_nv_cfg2 == CFG2_BLANK;
	endsequence
	rsp_has_req_a: assert property (o_prg_rsp.valid |-> $past(i_prg_req.valid))
		else $error("answer without request");
	prot_read_zero_a: assert property (o_prg_rsp.valid && !$past(o_nv_code_protect_n)
		&& $past(i_prg_req.cmd) == CMD_READ && !$past(i_prg_req.cfg_space)
		|-> o_prg_rsp.data == '0) else $error("protected read not zero");
	prot_refuse_a: assert property (i_prg_req.valid && o_prog_mode && !o_nv_code_protect_n
		&& i_prg_req.cmd == CMD_WRITE |-> !o_pm_req.we ##1 o_prg_rsp.refused)
		else $error("protected write not refused");
	erase_lift_a: assert property (erase_req |-> o_pm_req.erase ##1 erase_done)
		else $error("bulk erase did not lift protection");
	lp_bor_map_a: assert property (o_lp_brownout_en != o_nv_cfg2[BIT_LP_BOR_DIS])
		else $error("low power brownout enable wrong");
	unimpl_ones_a: assert property ((o_nv_cfg2 & CFG2_UNIMPL_MASK) == CFG2_UNIMPL_MASK)
		else $error("unimplemented bits not one");
	sw_region_a: assert property (i_self_wr.valid && !o_prog_mode && o_nv_cfg2[1:0] == 2'h2
		&& i_self_wr.addr <= REGION_TOP_2 |-> o_self_wr_refused && !o_pm_req.we)
		else $error("self write inside region not refused");
	lv_gate_a: assert property ((!o_nv_cfg2[BIT_LV_PROG] && !i_master_clear_pin_hv)[*4]
		|-> !o_prog_mode) else $error("programming entered without high voltage");
endmodule
bind cwp_config_word_protect cwp_checker #(.REGION_TOP_2(REGION_TOP_2)) u_cwp_checker (
	.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_prg_req(i_prg_req),
	.i_master_clear_pin_hv(i_master_clear_pin_hv), .o_prg_rsp(o_prg_rsp),
	.i_self_wr(i_self_wr), .o_self_wr_refused(o_self_wr_refused), .o_pm_req(o_pm_req),
	.o_nv_cfg2(o_nv_cfg2), .o_nv_code_protect_n(o_nv_code_protect_n),
	.o_prog_mode(o_prog_mode), .o_lp_brownout_en(o_lp_brownout_en)
);

// file: verification/cwp_prog_model.sv
`timescale 1ns/1ps
module cwp_prog_model (
	input wire logic i_core_clk,
	input wire cwp_pkg::cwp_prg_rsp_t i_rsp,
	output cwp_pkg::cwp_prg_req_t o_req
);
	import cwp_pkg::*;
	initial o_req = '0;
	// one word per request; released fields are inverted so stale values never match
	task automatic send(input cwp_cmd_t c, input logic [13:0] d, output cwp_prg_rsp_t r);
		@(posedge i_core_clk);
		o_req <= {1'h1, c, 1'h0, 11'h005, d};
		@(posedge i_core_clk);
		o_req <= {1'h0, ~o_req[27:0]};
		@(negedge i_core_clk);
		r = i_rsp;
	endtask
endmodule

// file: verification/cwp_config_word_protect_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module cwp_config_word_protect_bench;
	import cwp_pkg::*;
	logic clk = '0, rst_n = '0, hv = '0, key = '0, we = '0, re = '0, prot_n = 1'h1;
	logic sw_ref, ncp, pmode, lpb, bor;
	logic [13:0] cfg = 14'h2402, pm_rd = '0, ncfg;
	logic [3:0] ra = '0;
	logic [31:0] wd = '0, rd;
	cwp_self_wr_t sw = '0;
	cwp_prg_req_t req;
	cwp_prg_rsp_t rsp, r;
	cwp_pm_req_t pm;
	int failures = 0, tests_run = 0;
	always #50 clk = ~clk;
	always @(posedge clk) pm_rd <= pm.re ? {3'h0, pm.addr} ^ 14'h2a5a : ~pm_rd;
	cwp_config_word_protect u_cwp_config_word_protect (
		.i_core_clk(clk), .i_arst_n(rst_n), .i_nv_cfg2(cfg), .i_nv_code_protect_n(prot_n),
		.i_master_clear_pin_hv(hv), .i_lv_entry_key(key), .i_prg_req(req), .o_prg_rsp(rsp),
		.i_self_wr(sw), .o_self_wr_refused(sw_ref), .o_pm_req(pm), .i_pm_rdata(pm_rd),
		.o_nv_cfg2(ncfg), .o_nv_code_protect_n(ncp), .o_prog_mode(pmode),
		.o_lp_brownout_en(lpb), .o_bor_low_trip(bor), .o_stack_fault_reset_enable(),
		.i_reg_addr(ra),
		.i_reg_wdata(wd), .i_reg_we(we), .i_reg_re(re), .o_reg_rdata(rd)
	);
	cwp_prog_model u_cwp_prog_model (.i_core_clk(clk), .i_rsp(rsp), .o_req(req));
	task automatic close_out;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'h1;
		ra <= a;
		wd <= d;
		@(posedge clk);
		we <= '0;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		re <= 1'h1;
		ra <= a;
		@(posedge clk);
		re <= '0;
		@(negedge clk);
		`CHK("reg_rdata", e, rd)
	endtask
	task automatic swchk(input logic [10:0] a, input logic e);
		@(posedge clk);
		sw <= '{1'h1, a, 14'h0abc};
		@(negedge clk);
		`CHK("sw_refused", e, sw_ref)
		`CHK("pm_we", !e, pm.we)
		@(posedge clk);
		sw <= '0;
	endtask
	task automatic pchk(input cwp_cmd_t c, input logic f, input logic [13:0] e);
		u_cwp_prog_model.send(c, 14'h1555, r);
		`CHK("rsp_valid", 1'h1, r.valid)
		`CHK("rsp_refused", f, r.refused)
		if (c == CMD_READ) `CHK("rsp_data", e, r.data)
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		failures++;
		close_out;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		rdchk(REG_CFG2, 32'h0000_35fe);
		rdchk(4'hf, '0);
		`CHK("lp_brownout_en", 1'h1, lpb)
		`CHK("bor_low", 1'h1, bor)
		wr(REG_CTRL, 32'h0000_0001);
		swchk(11'h1ff, 1'h1);
		rdchk(REG_STATUS, 32'h0000_0014);
		wr(REG_STATUS, 32'h0000_0004);
		rdchk(REG_STATUS, 32'h0000_0010);
		swchk(11'h200, 1'h0);
		key <= 1'h1;
		repeat (4) @(posedge clk);
		`CHK("prog_mode", 1'h1, pmode)
		pchk(CMD_READ, 1'h0, 14'h2a5f);
		pchk(CMD_SET_PROT, 1'h0, '0);
		`CHK("prot_n", 1'h0, ncp)
		pchk(CMD_READ, 1'h0, '0);
		pchk(CMD_WRITE, 1'h1, '0);
		pchk(CMD_BULK_ERASE, 1'h0, '0);
		`CHK("cfg_blank", CFG2_BLANK, ncfg)
		pchk(CMD_READ, 1'h0, 14'h2a5f);
		@(posedge clk);
		rst_n <= '0;
		cfg <= 14'h0003;
		prot_n <= '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		repeat (6) @(posedge clk);
		`CHK("prog_mode", 1'h0, pmode)
		wr(REG_CTRL, 32'h0000_0001);
		swchk('0, 1'h0);
		hv <= 1'h1;
		repeat (4) @(posedge clk);
		`CHK("prog_mode", 1'h1, pmode)
		pchk(CMD_READ, 1'h0, '0);
		close_out;
	end
endmodule
